/* File: dv/spdtx_src.sv */
`timescale 1ns/10ps
`default_nettype none
module spdtx_src (
    input  wire logic       core_clk,
    input  wire logic [1:0] frame_format,
    input  wire logic [1:0] word_width,
    output logic            serial_clock,
    output logic            frame_sync,
    output logic            serial_data
);
    import spdtx_pkg::*;
    initial begin
        serial_clock = 1'b0;
        frame_sync   = 1'b1;
        serial_data  = 1'b0;
    end
    // Bits change while the clock is low; outside the word the line keeps toggling
    // 64 serial clocks of 12 cycles per frame: about 13 kHz, below 192 kHz
    task automatic half(input logic fs, input logic [23:0] word, input logic live);
        int n;
        int start;
        n = (word_width == WW_24) ? 24 : 16 + 2 * word_width;
        start = (frame_format == FMT_LEFT_JUST) ? 0 : (frame_format == FMT_RIGHT_JUST) ? 32 - n : 1;
        for (int k = 0; k < 32; k++) begin
            @(posedge core_clk);
            serial_clock <= 1'b0;
            frame_sync   <= fs;
            if (live && k >= start && k < start + n) begin
                serial_data <= word[23-(k-start)];
            end else begin
                serial_data <= ~serial_data;
            end
            repeat (6) @(posedge core_clk);
            serial_clock <= 1'b1;
            repeat (5) @(posedge core_clk);
        end
    endtask
    // Idle half at right level, then left and right words; clock stops low after
    task automatic frame(input logic [23:0] left, input logic [23:0] right);
        logic lf;
        lf = (frame_format == FMT_LEFT_JUST || frame_format == FMT_RIGHT_JUST);
        half(~lf, 24'h000000, 1'b0);
        half(lf, left, 1'b1);
        half(~lf, right, 1'b1);
        @(posedge core_clk);
        serial_clock <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
endmodule // spdtx_src
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import spdtx_pkg::*;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sck;
    logic        fs;
    logic        sd;
    logic        osc = 1'b0;
    logic [1:0]  fmt = FMT_I2S;
    logic [1:0]  ww = WW_16;
    logic        r384 = 1'b1;
    logic [23:0] sdata;
    logic        sleft;
    logic        svalid;
    logic        tick;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [24:0] seen_q[$];
    always #50 core_clk = ~core_clk;
    // Oversample clock at 384 or 256 x frame rate: period 2 or 3 cycles
    always begin
        @(posedge core_clk);
        osc <= 1'b1;
        repeat (r384 ? 1 : 2) @(posedge core_clk);
        osc <= 1'b0;
    end
    spdtx_input u_dut (.core_clk(core_clk), .arst_n(arst_n), .serial_clock(sck), .frame_sync(fs),
        .serial_data(sd), .oversample_clock(osc), .frame_format(fmt), .word_width(ww),
        .os_ratio_384(r384), .sample_data(sdata), .sample_left(sleft), .sample_valid(svalid),
        .biphase_tick(tick));
    spdtx_src u_src (.core_clk(core_clk), .frame_format(fmt), .word_width(ww), .serial_clock(sck),
        .frame_sync(fs), .serial_data(sd));
    always @(posedge core_clk) begin
        if (svalid === 1'b1) begin
            seen_q.push_back({sleft, sdata});
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Every framing code and width, each after a fresh reset
    task automatic test_frames();
        logic [23:0] l;
        logic [23:0] r;
        logic [23:0] m;
        for (int f = 0; f < 4; f++) begin
            for (int w = 0; w < 4; w++) begin
                @(posedge core_clk);
                arst_n <= 1'b0;
                fmt <= f[1:0];
                ww <= w[1:0];
                repeat (3) @(posedge core_clk);
                @(negedge core_clk);
                check({sleft, svalid, sdata}, 32'h0);
                @(posedge core_clk);
                arst_n <= 1'b1;
                seen_q.delete();
                l = 24'hA5C3F1 ^ {f[3:0], w[3:0], 16'h0000};
                r = 24'h3C5A96 ^ {16'h0000, w[3:0], f[3:0]};
                m = 24'hFFFFFF << (24 - ((w == 3) ? 24 : 16 + 2 * w));
                u_src.frame(l, r);
                check(seen_q.size(), 2);
                if (seen_q.size() >= 2) begin
                    check(seen_q[0], {1'b1, l & m});
                    check(seen_q[1], {1'b0, r & m});
                end
            end
        end
    endtask
    // Spacing of biphase ticks: 3 rises of a 2-cycle or 2 rises of a 3-cycle oversample clock
    task automatic test_tick(input logic ratio);
        int cnt;
        r384 <= ratio;
        for (int t = 0; t < 3; t++) begin
            cnt = 0;
            do begin
                @(negedge core_clk);
                cnt++;
            end while (tick !== 1'b1 && cnt < 100);
        end
        check(cnt, ratio ? int'(DIV_384) * 2 : int'(DIV_256) * 3);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        test_frames();
        test_tick(1'b1);
        test_tick(1'b0);
        test_done();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
endmodule // tb
`default_nettype wire

/* File: hdl/spdtx_input.sv */
`timescale 1ns/10ps
`default_nettype none
module spdtx_input
    import spdtx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        serial_clock,
    input  wire logic        frame_sync,
    input  wire logic        serial_data,
    input  wire logic        oversample_clock,
    input  wire logic [1:0]  frame_format,
    input  wire logic [1:0]  word_width,
    input  wire logic        os_ratio_384,
    output logic [23:0]      sample_data,
    output logic             sample_left,
    output logic             sample_valid,
    output logic             biphase_tick
);
    import spdtx_pkg::*;

    logic [3:0] pins_sync;
    logic       sck_s;
    logic       fs_s;
    logic       sd_s;
    logic       osc_s;
    logic       sck_prev;
    logic       osc_prev;
    logic       sck_rise;
    logic       osc_rise;
    logic       fs_prev;
    logic       fs_seen;
    logic       armed;
    logic       chan_fs;
    logic [5:0] cnt;
    logic [5:0] cur_idx;
    logic [5:0] start_idx;
    logic [5:0] nbits;
    logic [5:0] last_idx;
    logic       fs_edge;
    logic       in_word;
    logic       word_done;
    logic       fmt_i2s;
    logic [23:0] shreg;
    logic [23:0] next_shreg;
    logic [23:0] aligned;
    logic [1:0] div_cnt;
    logic [1:0] div_n;

    spdtx_sync #(
        .WIDTH (4)
    ) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in ({oversample_clock, serial_data, frame_sync, serial_clock}),
        .sync_out (pins_sync)
    );

    assign sck_s = pins_sync[0];
    assign fs_s  = pins_sync[1];
    assign sd_s  = pins_sync[2];
    assign osc_s = pins_sync[3];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_prev <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            sck_prev <= sck_s;
            osc_prev <= osc_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev;
    assign osc_rise = osc_s & ~osc_prev;

    // Framing and width decode
    assign fmt_i2s = (frame_format != FMT_LEFT_JUST) && (frame_format != FMT_RIGHT_JUST);

    always_comb begin
        case (word_width)
            WW_16:   nbits = BITS_16;
            WW_18:   nbits = BITS_18;
            WW_20:   nbits = BITS_20;
            default: nbits = BITS_24;
        endcase
        if (fmt_i2s) begin
            start_idx = DLY_I2S;
        end else if (frame_format == FMT_LEFT_JUST) begin
            start_idx = DLY_LJ;
        end else begin
            case (word_width)
                WW_16:   start_idx = DLY_RJ16;
                WW_18:   start_idx = DLY_RJ18;
                WW_20:   start_idx = DLY_RJ20;
                default: start_idx = DLY_RJ24;
            endcase
        end
    end

    assign fs_edge   = fs_seen && (fs_s != fs_prev);
    assign cur_idx   = fs_edge ? 6'h00 : cnt;
    assign last_idx  = start_idx + nbits - 6'h01;
    assign in_word   = (armed || fs_edge) && (cur_idx >= start_idx) && (cur_idx <= last_idx);
    assign word_done = sck_rise && in_word && (cur_idx == last_idx);
    assign next_shreg = {shreg[22:0], sd_s};
    assign aligned   = next_shreg << (6'(WORD_MAX) - nbits);

    // Frame sync tracking; nothing is assembled before the first transition
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fs_prev <= 1'b0;
            fs_seen <= 1'b0;
            armed   <= 1'b0;
            chan_fs <= 1'b0;
        end else if (sck_rise) begin
            fs_prev <= fs_s;
            fs_seen <= 1'b1;
            if (fs_edge) begin
                armed   <= 1'b1;
                chan_fs <= fs_s;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 6'h00;
        end else if (sck_rise) begin
            cnt <= (cur_idx == CNT_MAX) ? CNT_MAX : cur_idx + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= 24'h000000;
        end else if (sck_rise && in_word) begin
            shreg <= next_shreg;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_data  <= 24'h000000;
            sample_left  <= 1'b0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= word_done;
            if (word_done) begin
                sample_data <= aligned;
                sample_left <= fmt_i2s ? ~chan_fs : chan_fs;
            end
        end
    end

    // Biphase clock divider on the oversample clock
    assign div_n = os_ratio_384 ? DIV_384 : DIV_256;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt      <= 2'h0;
            biphase_tick <= 1'b0;
        end else begin
            biphase_tick <= 1'b0;
            if (osc_rise) begin
                if (div_cnt == div_n - 2'h1) begin
                    div_cnt      <= 2'h0;
                    biphase_tick <= 1'b1;
                end else if (div_cnt > div_n - 2'h1) begin
                    // Ratio lowered mid-count: restart rather than tick early
                    div_cnt <= 2'h0;
                end else begin
                    div_cnt <= div_cnt + 2'h1;
                end
            end
        end
    end

    AST_VALID_NEEDS_ARMED: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid |-> $past(armed) || $past(fs_edge))
        else $error("sample produced before first frame sync transition");

    AST_VALID_ON_SCK: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid |-> $past(sck_rise))
        else $error("sample completed without a rising serial clock");

    AST_LJ_END: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid && frame_format == FMT_LEFT_JUST |-> $past(cur_idx) == nbits - 6'h01)
        else $error("left-justified word ended at wrong bit");

    AST_I2S_END: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid && fmt_i2s |-> $past(cur_idx) == nbits)
        else $error("I2S word ended at wrong bit");

    AST_RJ_END: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid && frame_format == FMT_RIGHT_JUST |-> $past(cur_idx) == 6'h1F)
        else $error("right-justified LSB not just before next transition");

    AST_RJ24_START: assert property (@(posedge core_clk) disable iff (!arst_n)
        frame_format == FMT_RIGHT_JUST && word_width == WW_24 |-> start_idx == 6'h08)
        else $error("right-justified 24-bit MSB delay wrong");

    AST_LOW_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid && word_width == WW_16 |-> sample_data[7:0] == 8'h00)
        else $error("unused low bits of short word not zero");

    AST_DEFAULT_I2S: assert property (@(posedge core_clk) disable iff (!arst_n)
        frame_format == FMT_I2S |-> fmt_i2s && start_idx == 6'h01)
        else $error("default framing is not I2S");

    AST_CHANNEL: assert property (@(posedge core_clk) disable iff (!arst_n)
        sample_valid && fmt_i2s |-> sample_left == ~$past(chan_fs))
        else $error("I2S channel polarity wrong");

    AST_BIPHASE_DIV: assert property (@(posedge core_clk) disable iff (!arst_n)
        biphase_tick |-> $past(osc_rise) && $past(div_cnt) == $past(div_n) - 2'h1)
        else $error("biphase tick not on the dividing oversample edge");
endmodule // spdtx_input
`default_nettype wire

/* File: hdl/spdtx_pkg.sv */
`default_nettype none
package spdtx_pkg;
    // Framing codes; code zero is I2S so an unset select gives I2S
    localparam logic [1:0] FMT_I2S       = 2'h0;
    localparam logic [1:0] FMT_LEFT_JUST = 2'h1;
    localparam logic [1:0] FMT_RIGHT_JUST = 2'h2;
    // Word width codes
    localparam logic [1:0] WW_16 = 2'h0;
    localparam logic [1:0] WW_18 = 2'h1;
    localparam logic [1:0] WW_20 = 2'h2;
    localparam logic [1:0] WW_24 = 2'h3;
    localparam int         WORD_MAX = 24;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_18 = 6'h12;
    localparam logic [5:0] BITS_20 = 6'h14;
    localparam logic [5:0] BITS_24 = 6'h18;
    // Frame sync to MSB delay in serial clocks
    localparam logic [5:0] DLY_LJ   = 6'h00;
    localparam logic [5:0] DLY_I2S  = 6'h01;
    localparam logic [5:0] DLY_RJ16 = 6'h10;
    localparam logic [5:0] DLY_RJ18 = 6'h0E;
    localparam logic [5:0] DLY_RJ20 = 6'h0C;
    localparam logic [5:0] DLY_RJ24 = 6'h08;
    localparam logic [5:0] CNT_MAX  = 6'h3F;
    // Biphase clock is 128 x frame rate: oversample clock divided by 3 or 2
    localparam logic [1:0] DIV_384 = 2'h3;
    localparam logic [1:0] DIV_256 = 2'h2;
    localparam int         CORE_CLK_NS = 100;
endpackage : spdtx_pkg
`default_nettype wire

/* File: hdl/spdtx_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module spdtx_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_bad_width
        $error("spdtx_sync: WIDTH must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                meta[i]     <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta[i]     <= async_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end
endmodule // spdtx_sync
`default_nettype wire
